// >>> core/watchdog_map.svh
/*
  Register offsets, field positions, reset values and counts
  for the watchdog timer. Include by bare name; no logic.
*/
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// Byte offsets on the register bus
`define WD_LOAD_OFFSET     12'h000
`define WD_CONTROL_OFFSET  12'h004
`define WD_KICK_OFFSET     12'h008
`define WD_COUNT_OFFSET    12'h00C

// Control register fields
`define WD_CTRL_ENABLE_BIT  0
`define WD_CTRL_STATUS_BIT  1
`define WD_CTRL_HOLD_LSB    2
`define WD_CTRL_HOLD_MSB    4

// Reset values
`define WD_LOAD_RESET       16'h000F
`define WD_COUNT_RESET      16'h000F
`define WD_HOLD_EN_RESET    3'h0

// Slow tick periods per single decrement
`define WD_TICKS_PER_DEC    6'h21

`endif

// >>> core/watchdog_pkg.sv
/*
  Types shared by the watchdog timer modules.
  Assumes nothing of its surroundings.
*/
package watchdog_pkg;

  typedef logic [15:0] count_t;
  typedef logic [2:0]  hold_t;
  typedef logic [5:0]  prescale_t;

endpackage : watchdog_pkg

// >>> core/watchdog_count_if.sv
/*
  Carrier between the register front end and the down-counter.
  Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ns

interface watchdog_count_if;

  logic                  reloadReq;
  watchdog_pkg::count_t  loadValue;
  logic                  runEnable;
  logic                  holdActive;
  watchdog_pkg::count_t  count;
  logic                  expiry;

  modport ctrl (
    output reloadReq,
    output loadValue,
    output runEnable,
    output holdActive,
    input  count,
    input  expiry
  );

  modport cnt (
    input  reloadReq,
    input  loadValue,
    input  runEnable,
    input  holdActive,
    output count,
    output expiry
  );

endinterface : watchdog_count_if

// >>> core/watchdog_counter.sv
/*
  Prescaled 16-bit down-counter of the watchdog timer.
  Assumes slowTick is synchronous to clock and much slower.
*/
`timescale 1ns/1ns
`include "watchdog_map.svh"

module watchdog_counter (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Slow tick level
  input  wire logic          slowTick,
  // Front end
  watchdog_count_if.cnt      port
);

  logic                    tickPrev_reg;
  watchdog_pkg::prescale_t prescale_reg;
  watchdog_pkg::prescale_t prescale_next;
  watchdog_pkg::count_t    count_reg;
  watchdog_pkg::count_t    count_next;
  logic                    expiry_reg;
  logic                    expiry_next;

  wire logic tickEdge;
  wire logic advance;
  wire logic lastTick;

  // Advance only on slow tick edges, enabled and not held
  assign tickEdge = slowTick & ~tickPrev_reg;
  assign advance  = tickEdge & port.runEnable
                  & ~port.holdActive;
  assign lastTick = prescale_reg == (`WD_TICKS_PER_DEC - 6'h01);

  always_comb begin
    prescale_next = prescale_reg;
    count_next    = count_reg;
    expiry_next   = 1'b0;
    if (port.reloadReq) begin
      prescale_next = '0;
      count_next    = port.loadValue;
    end else if (advance) begin
      if (lastTick) begin
        prescale_next = '0;
        if (count_reg == 16'h0000) begin
          expiry_next = 1'b1;
          count_next  = port.loadValue;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else begin
        prescale_next = prescale_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickPrev_reg <= 1'b0;
      prescale_reg <= '0;
      count_reg    <= `WD_COUNT_RESET;
      expiry_reg   <= 1'b0;
    end else begin
      tickPrev_reg <= slowTick;
      prescale_reg <= prescale_next;
      count_reg    <= count_next;
      expiry_reg   <= expiry_next;
    end
  end

  assign port.count  = count_reg;
  assign port.expiry = expiry_reg;

endmodule : watchdog_counter

// >>> core/embedded_watchdog_timer.sv
/*
  Watchdog timer top: APB register slave, hold gating, expiry
  reset pulse and sticky status. Assumes an APB master on clock.
*/
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "watchdog_map.svh"

module embedded_watchdog_timer (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Slow tick and hold sources
  input  wire logic          slowTickClock,
  input  wire logic [2:0]    watchdogHoldInputs,
  input  wire logic          debugWatchdogEnable,
  // Expiry reset pulse
  output logic               expiryReset
);

  function automatic logic addrIs(input logic [11:0] a,
                                  input logic [11:0] off);
    addrIs = a == off;
  endfunction : addrIs

  watchdog_count_if cntBus ();

  watchdog_pkg::count_t  load_reg;
  logic                  enable_reg;
  logic                  status_reg;
  logic                  status_next;
  watchdog_pkg::hold_t   holdEnable_reg;
  logic                  pready_reg;
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;
  logic                  pslverr_reg;
  logic                  expiryReset_reg;

  wire logic                 setupPhase;
  wire logic                 writeDone;
  wire logic                 selLoad;
  wire logic                 selControl;
  wire logic                 selKick;
  wire logic                 selCount;
  wire logic                 mapped;
  wire logic                 loadWrite;
  wire logic                 controlWrite;
  wire logic                 kickWrite;
  wire watchdog_pkg::hold_t  holdSources;
  wire logic                 holdAny;
  wire logic [31:0]          controlWord;

  // Bus phase decode
  assign setupPhase = psel & ~penable & ~pready_reg;
  assign writeDone  = psel & penable & pready_reg & pwrite;
  assign selLoad    = addrIs(paddr, `WD_LOAD_OFFSET);
  assign selControl = addrIs(paddr, `WD_CONTROL_OFFSET);
  assign selKick    = addrIs(paddr, `WD_KICK_OFFSET);
  assign selCount   = addrIs(paddr, `WD_COUNT_OFFSET);
  assign mapped     = selLoad | selControl | selKick | selCount;

  assign loadWrite    = writeDone & selLoad;
  assign controlWrite = writeDone & selControl;
  assign kickWrite    = writeDone & selKick & enable_reg;

  // Hold sources and gating
  assign holdSources = {watchdogHoldInputs[2] | ~debugWatchdogEnable,
                        watchdogHoldInputs[1:0]};
  assign holdAny     = |(holdSources & holdEnable_reg);

  assign controlWord = {27'h0000000, holdEnable_reg, status_reg,
                        enable_reg};

  // Counter hookup
  assign cntBus.reloadReq  = loadWrite | kickWrite;
  assign cntBus.loadValue  = loadWrite ? pwdata[15:0] : load_reg;
  assign cntBus.runEnable  = enable_reg;
  assign cntBus.holdActive = holdAny;

  watchdog_counter counter (
    .clock    (clock),
    .rst      (rst),
    .slowTick (slowTickClock),
    .port     (cntBus)
  );

  // Read data; kick reads zero
  always_comb begin
    prdata_next = 32'h00000000;
    if (selLoad) begin
      prdata_next = {16'h0000, load_reg};
    end else if (selControl) begin
      prdata_next = controlWord;
    end else if (selCount) begin
      prdata_next = {16'h0000, cntBus.count};
    end else begin
      prdata_next = 32'h00000000;
    end
  end

  // Sticky status; set wins over write-one clear
  always_comb begin
    status_next = status_reg;
    if (controlWrite && pwdata[`WD_CTRL_STATUS_BIT]) begin
      status_next = 1'b0;
    end
    if (cntBus.expiry) begin
      status_next = 1'b1;
    end
  end

  // Bus answer, one wait-free access phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setupPhase;
      if (setupPhase) begin
        prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
        pslverr_reg <= ~mapped;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      load_reg       <= `WD_LOAD_RESET;
      enable_reg     <= 1'b0;
      holdEnable_reg <= `WD_HOLD_EN_RESET;
      status_reg     <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (loadWrite) begin
        load_reg <= pwdata[15:0];
      end
      if (controlWrite) begin
        enable_reg     <= pwdata[`WD_CTRL_ENABLE_BIT];
        holdEnable_reg <= pwdata[`WD_CTRL_HOLD_MSB:`WD_CTRL_HOLD_LSB];
      end
    end
  end

  // One-cycle expiry reset pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      expiryReset_reg <= 1'b0;
    end else begin
      expiryReset_reg <= cntBus.expiry;
    end
  end

  assign pready      = pready_reg;
  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg;
  assign expiryReset = expiryReset_reg;

endmodule : embedded_watchdog_timer

// >>> testbench/watchdog_chk.sv
/* Port checker for the watchdog top.
   Assumes binding into embedded_watchdog_timer. */
`timescale 1ns/1ns
module watchdog_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Expiry
  input wire logic        expiryReset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire acc = psel && penable && pready;
  wire mapped = (paddr <= 12'h00C) && (paddr[1:0] == 2'h0);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready late");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready too long");
  kick_zero_a: assert property (acc && !pwrite && paddr == 12'h008 |->
    prdata == 32'h0) else $error("kick read not zero");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped");
  upper_zero_a: assert property (acc && !pwrite |->
    prdata[31:16] == 16'h0) else $error("upper bits set");
  expiry_pulse_a: assert property (expiryReset |=> !expiryReset)
    else $error("expiry pulse long");
  expiry_gap_a: assert property ($rose(expiryReset) |=>
    !expiryReset [*8]) else $error("expiry too soon");
endmodule : watchdog_chk

bind embedded_watchdog_timer watchdog_chk watchdog_chk_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .expiryReset(expiryReset));

// >>> testbench/apb_host_model.sv
/* Controller core model: APB master with one transfer task.
   Assumes a slave on the same clock answering with pready. */
`timescale 1ns/1ns
module apb_host_model (
  // Clock
  input  wire logic        clock,
  // APB master
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [11:0]      paddr = 12'h000,
  output logic [31:0]      pwdata = 32'h0,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : apb_host_model

// >>> testbench/test_embedded_watchdog_timer.sv
/* Self-checking bench for the watchdog timer.
   Assumes the APB host model and the port checker. */
`timescale 1ns/1ns
module test_embedded_watchdog_timer;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  tickDiv = 2'h0;
  logic [2:0]  holdIn = 3'h0;
  logic        dbgEn = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, expiryReset, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] seed = 16'h8D88;
  logic [15:0] ld;
  logic [31:0] rv [4] = '{32'hF, 32'h0, 32'h0, 32'hF};
  int          fail_count = 0, checks_done = 0, n, hb;
  always #4 clock = ~clock;
  always @(posedge clock) tickDiv <= tickDiv + 2'h1;
  apb_host_model apb_host_model_i (.clock(clock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  embedded_watchdog_timer embedded_watchdog_timer_i (.clock(clock),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .slowTickClock(tickDiv[1]),
    .watchdogHoldInputs(holdIn), .debugWatchdogEnable(dbgEn),
    .expiryReset(expiryReset));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Clocks from enable to expiry: four clocks a tick
  function automatic int exp_clocks(input logic [15:0] l);
    return (int'(l) + 1) * 33 * 4 + 2;
  endfunction : exp_clocks
  task automatic acc(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    apb_host_model_i.xfer(a, w, d, v, er);
  endtask : acc
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wrap_up;
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc(12'(i * 4), 1'b0, 32'h0);
      chk("reset", rv[i], v);
    end
    acc(12'h010, 1'b1, 32'hFFFFFFFF);
    chk("slverr", 32'h1, {31'h0, er});
    repeat (300) @(posedge clock);
    acc(12'h00C, 1'b0, 32'h0);
    chk("idle count", 32'hF, v);
    seed = lfsr(seed);
    ld = 16'(seed[1:0]) + 16'h2;
    acc(12'h000, 1'b1, {seed, ld});
    acc(12'h004, 1'b1, 32'h1);
    n = 0;
    while (expiryReset !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    chk("interval", 32'h1, 32'(n > exp_clocks(ld) - 6 &&
        n < exp_clocks(ld) + 6));
    acc(12'h004, 1'b0, 32'h0);
    chk("status", 32'h3, v);
    acc(12'h00C, 1'b0, 32'h0);
    chk("reload", {16'h0, ld}, v);
    acc(12'h004, 1'b1, 32'h1);
    acc(12'h004, 1'b0, 32'h0);
    chk("w0 status", 32'h3, v);
    acc(12'h004, 1'b1, 32'h3);
    acc(12'h004, 1'b0, 32'h0);
    chk("w1 status", 32'h1, v);
    repeat (150) @(posedge clock);
    acc(12'h008, 1'b1, 32'h0);
    acc(12'h00C, 1'b0, 32'h0);
    chk("kick", {16'h0, ld}, v);
    repeat (150) @(posedge clock);
    acc(12'h004, 1'b1, 32'h0);
    acc(12'h008, 1'b1, 32'h0);
    acc(12'h00C, 1'b0, 32'h0);
    chk("kick off", {16'h0, ld - 16'h1}, v);
    for (int i = 0; i < 4; i++) begin
      hb = (i == 3) ? 2 : i;
      holdIn <= (i < 3) ? 3'h1 << i : 3'h0;
      dbgEn <= (i != 3);
      acc(12'h004, 1'b1, 32'h1 | (32'h4 << hb));
      acc(12'h000, 1'b1, {16'h0, ld});
      repeat (300) @(posedge clock);
      acc(12'h00C, 1'b0, 32'h0);
      chk("held", {16'h0, ld}, v);
      holdIn <= ~(3'h1 << hb);
      dbgEn <= 1'b1;
      repeat (150) @(posedge clock);
      acc(12'h00C, 1'b0, 32'h0);
      chk("resumed", {16'h0, ld - 16'h1}, v);
    end
    // Load of zero expires after one prescale span
    acc(12'h000, 1'b1, 32'h0);
    repeat (150) @(posedge clock);
    acc(12'h004, 1'b0, 32'h0);
    chk("status kept", 32'h13, v);
    // Mid-run reset returns every register to its default
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc(12'(i * 4), 1'b0, 32'h0);
      chk("reset again", rv[i], v);
    end
    wrap_up();
  end
endmodule : test_embedded_watchdog_timer
